// file: rng_consts.vh
// Register offsets, field positions, reset values and timing counts for the random generator
`ifndef RNG_CONSTS_VH
`define RNG_CONSTS_VH
`define RNG_OFF_IDENT 16'h6000
`define RNG_OFF_CTRL 16'h6004
`define RNG_OFF_POLY_LO 16'h6008
`define RNG_OFF_POLY_HI 16'h600C
`define RNG_OFF_OUT_LO 16'h6010
`define RNG_OFF_OUT_HI 16'h6014
`define RNG_OFF_SEED_LO 16'h6018
`define RNG_OFF_SEED_HI 16'h601C
`define RNG_OFF_COUNT 16'h6020
`define RNG_ADDR_W 16
`define RNG_CTRL_LEN_MSB 7
`define RNG_CTRL_TRUE_EN 8
`define RNG_CTRL_PSEUDO_EN 9
`define RNG_CTRL_CONTINUOUS_SHIFT_ENABLE 10
`define RNG_CTRL_MODE 11
`define RNG_CTRL_LOAD 12
`define RNG_CTRL_IMPL_MSB 12
`define RNG_CTRL_RESET 13'h0064
`define RNG_POLY_RESET 32'hFFFF0000
`define RNG_OUT_RESET 32'hFFFFFFFF
`define RNG_BLOCK_ID 16'h5A3C
`define RNG_BLOCK_VERSION 8'h01
`define RNG_BLOCK_REVISION 8'h00
`define RNG_COUNT_W 7
`define RNG_COUNT_FULL 7'h20
`define RNG_RESP_OKAY 2'b00
`define RNG_RESP_SLVERR 2'b10
`define RNG_CLK_MHZ 50
`define RNG_TRUE_RATE_MBPS 25
`define RNG_TRUE_DIV ((`RNG_CLK_MHZ + `RNG_TRUE_RATE_MBPS - 1) / `RNG_TRUE_RATE_MBPS)
`endif

// file: rng_bias_corrector.v
// Von Neumann bias corrector for the raw ring-oscillator bit stream
`timescale 1ns/100ps
`default_nettype none
module rng_bias_corrector (
    input wire sys_clk,
    input wire rst,
    input wire enable,
    input wire sample,
    input wire raw_bit,
    output reg bit_valid,
    output reg bit_value
);
    reg have_first;
    reg first_bit;

    // Pairs of samples: 01 and 10 give one unbiased bit, 00 and 11 are dropped
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            have_first <= 1'b0;
            first_bit <= 1'b0;
            bit_valid <= 1'b0;
            bit_value <= 1'b0;
        end else begin
            bit_valid <= 1'b0;
            if (!enable) begin
                have_first <= 1'b0;
            end else if (sample) begin
                if (!have_first) begin
                    have_first <= 1'b1;
                    first_bit <= raw_bit;
                end else begin
                    have_first <= 1'b0;
                    if (first_bit != raw_bit) begin
                        bit_valid <= 1'b1;
                        bit_value <= first_bit;
                    end
                end
            end
        end
    end
endmodule // rng_bias_corrector
`default_nettype wire

// file: rng_top.v
// Random number generator top: AXI4-Lite registers, entropy accumulator and 64-bit LFSR
`timescale 1ns/100ps
`default_nettype none
`include "rng_consts.vh"
module rng_top (
    input wire sys_clk,
    input wire rst,
    input wire entropy_raw,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // Divider end count, cut to the counter width on purpose
    localparam integer DIV_LAST_FULL = `RNG_TRUE_DIV - 1;
    localparam [1:0] DIV_LAST = DIV_LAST_FULL[1:0];

    reg [`RNG_CTRL_IMPL_MSB:0] ctrl;
    reg [31:0] poly_lo;
    reg [31:0] poly_hi;
    reg [63:0] lfsr;
    reg [31:0] seed_lo;
    reg [31:0] seed_hi;
    reg [`RNG_COUNT_W-1:0] count;
    reg out_taken;
    reg ent_meta;
    reg ent_sync;
    reg ent_prev;
    reg [1:0] div_cnt;
    reg aw_held;
    reg w_held;
    reg [31:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [63:0] next_lfsr;
    reg [31:0] rd_word;
    reg rd_ok;
    reg wr_ok;
    wire true_on;
    wire pseudo_on;
    wire sample;
    wire entropy_bit;
    wire cb_valid;
    wire cb_value;
    wire wr_fire;
    wire [31:0] ctrl_merged;

    // Merge a write word into a register honouring byte strobes
    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge_bytes[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    // Register index decode from a byte address; 4'hF marks an unmapped one
    function [3:0] reg_index;
        input [31:0] addr;
        begin
            case (addr[`RNG_ADDR_W-1:0])
                `RNG_OFF_IDENT: reg_index = 4'h0;
                `RNG_OFF_CTRL: reg_index = 4'h1;
                `RNG_OFF_POLY_LO: reg_index = 4'h2;
                `RNG_OFF_POLY_HI: reg_index = 4'h3;
                `RNG_OFF_OUT_LO: reg_index = 4'h4;
                `RNG_OFF_OUT_HI: reg_index = 4'h5;
                `RNG_OFF_SEED_LO: reg_index = 4'h6;
                `RNG_OFF_SEED_HI: reg_index = 4'h7;
                `RNG_OFF_COUNT: reg_index = 4'h8;
                default: reg_index = 4'hF;
            endcase
        end
    endfunction

    assign true_on = ctrl[`RNG_CTRL_TRUE_EN];
    assign pseudo_on = ctrl[`RNG_CTRL_PSEUDO_EN];
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    // Full-width control word after byte strobes; only the implemented bits are kept
    assign ctrl_merged = merge_bytes({19'h0, ctrl}, w_data, w_strb);

    // Entropy pin is asynchronous, so two flops before anything looks at it
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ent_meta <= 1'b0;
            ent_sync <= 1'b0;
            ent_prev <= 1'b0;
            div_cnt <= 2'b00;
        end else begin
            ent_meta <= entropy_raw;
            ent_sync <= ent_meta;
            ent_prev <= ent_sync;
            if (!true_on || div_cnt == DIV_LAST) begin
                div_cnt <= 2'b00;
            end else begin
                div_cnt <= div_cnt + 2'b01;
            end
        end
    end

    // Sampling at the clock over the divider bounds the output rate
    assign sample = true_on && (div_cnt == DIV_LAST);
    // Enhanced mode folds in the synchronised value from one clock earlier to whiten slow oscillator drift
    assign entropy_bit = (true_on && ctrl[`RNG_CTRL_MODE]) ? (ent_sync ^ ent_prev) : ent_sync;

    rng_bias_corrector u_bias (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(true_on),
        .sample(sample),
        .raw_bit(entropy_bit),
        .bit_valid(cb_valid),
        .bit_value(cb_value)
    );

    // Entropy accumulator: high word fills first, counted, then bits ripple into the low word
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seed_lo <= 32'h00000000;
            seed_hi <= 32'h00000000;
            count <= {`RNG_COUNT_W{1'b0}};
        end else if (cb_valid) begin
            seed_hi <= {seed_hi[30:0], cb_value};
            seed_lo <= {seed_lo[30:0], seed_hi[31]};
            // Software may leave the count above full; it must not wrap from there
            if (count < `RNG_COUNT_FULL) begin
                count <= count + 7'h01;
            end
        end else if (wr_fire && reg_index(aw_addr) == 4'h8 && w_strb[0]) begin
            count <= w_data[`RNG_COUNT_W-1:0];
        end
    end

    // LFSR step: taps are polynomial bits below the length, feedback fed in at bit 0, bits from the length up cleared
    always @* begin : lfsr_step
        integer k;
        reg fb;
        reg [63:0] poly;
        reg [7:0] len;
        fb = 1'b0;
        poly = {poly_hi, poly_lo};
        len = ctrl[`RNG_CTRL_LEN_MSB:0];
        for (k = 0; k < 64; k = k + 1) begin
            if (k < len && poly[k]) begin
                fb = fb ^ lfsr[k];
            end
        end
        next_lfsr = {lfsr[62:0], fb};
        for (k = 0; k < 64; k = k + 1) begin
            if (k >= len) begin
                next_lfsr[k] = 1'b0;
            end
        end
    end

    // Pseudo generator register: seed load wins, then stepping by mode
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lfsr <= {`RNG_OUT_RESET, `RNG_OUT_RESET};
            out_taken <= 1'b0;
        end else begin
            if (ctrl[`RNG_CTRL_LOAD]) begin
                lfsr <= {seed_hi, seed_lo};
                out_taken <= 1'b0;
            end else if (wr_fire && reg_index(aw_addr) == 4'h4) begin
                // A written value is fresh, so an old read must not step it
                lfsr[31:0] <= merge_bytes(lfsr[31:0], w_data, w_strb);
                out_taken <= 1'b0;
            end else if (wr_fire && reg_index(aw_addr) == 4'h5) begin
                lfsr[63:32] <= merge_bytes(lfsr[63:32], w_data, w_strb);
                out_taken <= 1'b0;
            end else if (pseudo_on && ctrl[`RNG_CTRL_CONTINUOUS_SHIFT_ENABLE]) begin
                lfsr <= next_lfsr;
            end else if (pseudo_on && out_taken) begin
                lfsr <= next_lfsr;
                out_taken <= 1'b0;
            end
            // Reading the high word marks the value as removed
            if (s_axi_arvalid && s_axi_arready && reg_index(s_axi_araddr) == 4'h5) begin
                out_taken <= 1'b1;
            end
        end
    end

    // Control and polynomial registers; the load bit clears one cycle after it is set
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= `RNG_CTRL_RESET;
            poly_lo <= `RNG_POLY_RESET;
            poly_hi <= `RNG_POLY_RESET;
        end else begin
            if (ctrl[`RNG_CTRL_LOAD]) begin
                ctrl[`RNG_CTRL_LOAD] <= 1'b0;
            end
            if (wr_fire) begin
                case (reg_index(aw_addr))
                    4'h1: ctrl <= ctrl_merged[`RNG_CTRL_IMPL_MSB:0];
                    4'h2: poly_lo <= merge_bytes(poly_lo, w_data, w_strb);
                    4'h3: poly_hi <= merge_bytes(poly_hi, w_data, w_strb);
                    default: ;
                endcase
            end
        end
    end

    // Read mux; unimplemented bits are zero-filled
    always @* begin
        rd_ok = 1'b1;
        case (reg_index(s_axi_araddr))
            4'h0: rd_word = {`RNG_BLOCK_ID, `RNG_BLOCK_VERSION, `RNG_BLOCK_REVISION};
            4'h1: rd_word = {19'h0, ctrl};
            4'h2: rd_word = poly_lo;
            4'h3: rd_word = poly_hi;
            4'h4: rd_word = lfsr[31:0];
            4'h5: rd_word = lfsr[63:32];
            4'h6: rd_word = seed_lo;
            4'h7: rd_word = seed_hi;
            4'h8: rd_word = {25'h0, count};
            default: begin
                rd_word = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @* begin
        wr_ok = (reg_index(aw_addr) != 4'hF);
    end

    // AXI4-Lite write channels: address and data latch independently, response after both
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RNG_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `RNG_RESP_OKAY : `RNG_RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel: data sampled at the address handshake
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RNG_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `RNG_RESP_OKAY : `RNG_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // rng_top
`default_nettype wire

// file: rng_top_sva.sv
// Bus timing and register readback checker for the random generator top
`timescale 1ns/100ps
`default_nettype none
`include "rng_consts.vh"
module rng_top_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Read address taken at this edge
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire [15:0] ra = s_axi_araddr[15:0];
    property p_ident;
        ar_hs && ra == `RNG_OFF_IDENT |=> s_axi_rvalid && s_axi_rdata == {`RNG_BLOCK_ID,
            `RNG_BLOCK_VERSION, `RNG_BLOCK_REVISION};
    endproperty
    a_ident: assert property (p_ident) else $error("identification word wrong");
    property p_ctrl_unused;
        ar_hs && ra == `RNG_OFF_CTRL |=> s_axi_rvalid && s_axi_rdata[31:12] == 20'h0;
    endproperty
    a_ctrl_unused: assert property (p_ctrl_unused) else $error("control high bits set");
    property p_count;
        ar_hs && ra == `RNG_OFF_COUNT |=> s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[6:0] <= 7'h20;
    endproperty
    a_count: assert property (p_count) else $error("count out of range");
    property p_unmapped;
        ar_hs && ra == 16'h6024 |=> s_axi_rresp == `RNG_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped early");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped early");
    property p_aw_take;
        $rose(s_axi_awvalid) |-> ##[1:2] s_axi_awready;
    endproperty
    a_aw_take: assert property (p_aw_take) else $error("write address not taken");
    property p_b_after;
        s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write answer late");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
endmodule // rng_top_sva
bind rng_top rng_top_sva i_sva (.sys_clk, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// file: tb_rng_top.sv
// Self-checking testbench for the random generator top
`timescale 1ns/100ps
`default_nettype none
module tb_rng_top;
    logic sys_clk = 0, rst = 1, ent_on = 0, entropy_raw = 1;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, lf = 32'ha133a078, el = 32'ha133a078;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid;
    logic arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [63:0] v, p, w;
    logic [31:0] d, s0, s1;
    logic [7:0] n;
    int fail_count = 0, num_checks = 0, k, hit;
    rng_top i_dut (.sys_clk(sys_clk), .rst(rst), .entropy_raw(entropy_raw),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial forever #10 sys_clk = ~sys_clk;
    function automatic [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // One LFSR step, taps limited to bits below the length
    function automatic [63:0] stp(input [63:0] x, input [63:0] q, input [7:0] len);
        logic [63:0] m;
        m = (len >= 64) ? ~64'h0 : ((64'h1 << len) - 64'h1);
        stp = {x[62:0], ^(x & q & m)} & m;
    endfunction
    // Separate entropy stream so stimulus order never races the main sequence
    always @(posedge sys_clk) begin
        el <= nx(el);
        entropy_raw <= ent_on ? el[0] : 1'b1;
    end
    task automatic chk(input [31:0] got, input [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input [15:0] a, input [31:0] x);
        @(posedge sys_clk);
        awaddr <= {16'h0, a};
        wdata <= x;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        resp = bresp;
        bready <= 0;
    endtask
    task automatic rd(input [15:0] a);
        @(posedge sys_clk);
        araddr <= {16'h0, a};
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 0;
    endtask
    task automatic rd64(output [63:0] x);
        rd(16'h6010);
        x[31:0] = d;
        rd(16'h6014);
        x[63:32] = d;
    endtask
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        rd(16'h6000); chk(d, 32'h5A3C0100);
        rd(16'h6004); chk(d, 32'h64);
        rd(16'h600C); chk(d, 32'hFFFF0000);
        rd64(w); chk(w[63:32] & w[31:0], 32'hFFFFFFFF);
        rd(16'h601C); chk(d, 32'h0);
        rd(16'h6020); chk(d, 32'h0);
        wr(16'h6004, 32'hFFFFE0FF); rd(16'h6004); chk(d, 32'hFF);
        wr(16'h6018, 32'h1234ABCD); rd(16'h6018); chk(d, 32'h0);
        wr(16'h6024, 32'h1); chk(resp, 2'b10);
        rd(16'h6024); chk(resp, 2'b10);
        wr(16'h6020, 32'hFFFFFF9F); rd(16'h6020); chk(d, 32'h1F);
        wr(16'h6020, 32'h0);
        // On-demand stepping, length 32 first so upper taps must be ignored
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf); v[31:0] = lf; lf = nx(lf); v[63:32] = lf;
            lf = nx(lf); p[31:0] = lf; lf = nx(lf); p[63:32] = lf | 32'hF0000001;
            n = (i == 0) ? 8'd32 : 8'd64;
            wr(16'h6004, n);
            wr(16'h6008, p[31:0]); wr(16'h600C, p[63:32]);
            wr(16'h6010, v[31:0]); wr(16'h6014, v[63:32]);
            rd(16'h600C); chk(d, p[63:32]);
            wr(16'h6004, {n, 24'h0} >> 24 | 32'h200);
            rd64(w); chk(w[31:0], v[31:0]); chk(w[63:32], v[63:32]);
            v = stp(v, p, n);
            repeat (5) @(posedge sys_clk);
            rd64(w); chk(w[31:0], v[31:0]); chk(w[63:32], v[63:32]);
            v = stp(v, p, n);
            wr(16'h6004, n);
            rd64(w); rd64(w); chk(w[31:0], v[31:0]); chk(w[63:32], v[63:32]);
        end
        // Free-running stepping must land on a later point of the same sequence
        wr(16'h6004, 32'h640);
        rd(16'h6010);
        hit = 0;
        w = v;
        for (k = 0; k < 60; k++) begin
            w = stp(w, p, 8'd64);
            if (w[31:0] == d) hit = 1;
        end
        chk(hit, 1);
        wr(16'h6004, 32'h40);
        ent_on <= 1;
        repeat (100) @(posedge sys_clk);
        rd(16'h6020); chk(d, 32'h0);
        ent_on <= 0;
        wr(16'h6004, 32'h140);
        repeat (100) @(posedge sys_clk);
        rd(16'h6020); chk(d, 32'h0);
        ent_on <= 1;
        wr(16'h6004, 32'h940);
        repeat (1000) @(posedge sys_clk);
        rd(16'h6020); chk(d, 32'h20);
        wr(16'h6004, 32'h40);
        rd(16'h6018); s0 = d;
        rd(16'h601C); s1 = d;
        wr(16'h6004, 32'h1040);
        rd(16'h6004); chk(d, 32'h40);
        rd64(w); chk(w[31:0], s0); chk(w[63:32], s1);
        close_out();
    end
endmodule // tb_rng_top
`default_nettype wire
